// file: rtl/qsffc_pkg.sv
/*
 * Shared constants, types and helpers of the quad serial Flash frame
 * controller. Assumes a 32-bit AXI4-Lite register bus with byte offsets.
 */
package qsffc_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h08;
  localparam logic [7:0] OFF_IER = 8'h14;
  localparam logic [7:0] OFF_IDR = 8'h18;
  localparam logic [7:0] OFF_IMR = 8'h1c;
  localparam logic [7:0] OFF_INSTR = 8'h20;
  localparam logic [7:0] OFF_ADDR = 8'h24;
  localparam logic [7:0] OFF_TXD = 8'h28;
  localparam logic [7:0] OFF_RXD = 8'h2c;
  localparam logic [7:0] OFF_IFR = 8'h34;
  localparam logic [7:0] OFF_SKEY = 8'h38;

  ////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int IRQ_INSTRUCTION_END_IRQ_EN = 10;
  localparam int IRQ_CSS = 9;
  localparam int IRQ_CSR = 8;
  localparam int IRQ_RECEIVE_OVERRUN_IRQ_EN = 3;
  localparam int IRQ_TRANSMIT_REGS_DRAINED_IRQ_EN = 2;
  localparam int IRQ_TRANSMIT_HOLDING_FREE_IRQ_EN = 1;
  localparam int IRQ_RECEIVE_HOLDING_FULL_IRQ_EN = 0;
  localparam logic [31:0] IRQ_IMPL = 32'h0000_070f;
  localparam int IFR_ADDRESS_LENGTH_SEL = 10;
  localparam int IFR_OPTION_CODE_LENGTH = 8;
  localparam int IFR_DATA_PHASE_EN = 7;
  localparam int IFR_OPTION_PHASE_EN = 6;
  localparam int IFR_ADDRESS_PHASE_EN = 5;
  localparam int IFR_INSTRUCTION_PHASE_EN = 4;
  localparam int IFR_WIDTH = 0;
  localparam int IFR_TFR = 12;
  localparam int CTRL_START = 0;
  localparam int CTRL_SCREN = 1;
  localparam int CTRL_BUSY = 31;

  ////////////////////////////////////////////////////////////////////////
  // Reset values, counts and codes
  localparam logic [31:0] REG_RST = 32'h0000_0000;
  localparam logic [5:0] INST_BITS = 6'h08;
  localparam logic [5:0] ADDR_SHORT = 6'h18;
  localparam logic [5:0] ADDR_LONG = 6'h20;
  localparam logic [5:0] DATA_BITS = 6'h08;
  localparam logic [1:0] TFR_PLAIN_WRITE = 2'h2;
  localparam logic [1:0] TFR_MEM_WRITE = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE, ST_INST, ST_ADDR, ST_OPT, ST_DATA, ST_DONE
  } qsffc_state_t;

  ////////////////////////////////////////////////////////////////////////
  // Lanes for a phase (0 instruction, 1 address/option, 2 data)
  function automatic logic [2:0] lane_cnt(input logic [2:0] w,
                                          input logic [1:0] ph);
    case (w)
      3'h1: lane_cnt = (ph == 2'h2) ? 3'h2 : 3'h1;
      3'h2: lane_cnt = (ph == 2'h2) ? 3'h4 : 3'h1;
      3'h3: lane_cnt = (ph != 2'h0) ? 3'h2 : 3'h1;
      3'h4: lane_cnt = (ph != 2'h0) ? 3'h4 : 3'h1;
      3'h5: lane_cnt = 3'h2;
      3'h6: lane_cnt = 3'h4;
      default: lane_cnt = 3'h1;
    endcase
  endfunction

  function automatic logic [5:0] opt_bits(input logic [1:0] l);
    case (l)
      2'h0: opt_bits = 6'h01;
      2'h1: opt_bits = 6'h02;
      2'h2: opt_bits = 6'h04;
      default: opt_bits = 6'h08;
    endcase
  endfunction

  function automatic logic [3:0] lane_oe(input logic [2:0] ln);
    lane_oe = (ln == 3'h4) ? 4'hf : (ln == 3'h2) ? 4'h3 : 4'h1;
  endfunction

  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

endpackage

// file: rtl/qsffc_sync.sv
/*
 * Three-stage input synchroniser with agreement filter.
 * Assumes d is asynchronous to aclk.
 */
`timescale 1ns/1ns
module qsffc_sync #(
  parameter int W = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] ff1_r, ff2_r, ff3_r, q_r;
  logic [W-1:0] q_nxt;

  // Only bits on which stage two and three agree are taken
  always_comb begin
    q_nxt = (ff2_r & ~(ff2_r ^ ff3_r)) | (q_r & (ff2_r ^ ff3_r));
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ff1_r <= '0;
      ff2_r <= '0;
      ff3_r <= '0;
      q_r <= '0;
    end else begin
      ff1_r <= d;
      ff2_r <= ff1_r;
      ff3_r <= ff2_r;
      q_r <= q_nxt;
    end
  end

  assign q = q_r;
endmodule // qsffc_sync

// file: rtl/qsffc_irq.sv
/*
 * Sticky interrupt status, enable mask and level interrupt output.
 * Assumes one-cycle event and write pulses from the same clock.
 */
`timescale 1ns/1ns
module qsffc_irq (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] ev_set,
  input wire logic [31:0] stat_clr,
  input wire logic [31:0] en_set,
  input wire logic [31:0] en_clr,
  output logic [31:0] status,
  output logic [31:0] mask,
  output logic irq
);
  logic [31:0] status_r, status_nxt, mask_r, mask_nxt;
  logic irq_r, irq_nxt;

  // Set wins over a clear in the same cycle
  always_comb begin
    status_nxt = ((status_r & ~stat_clr) | ev_set) & qsffc_pkg::IRQ_IMPL;
    mask_nxt = ((mask_r & ~en_clr) | en_set) & qsffc_pkg::IRQ_IMPL;
    irq_nxt = |(status_r & mask_r);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_r <= qsffc_pkg::REG_RST;
      mask_r <= qsffc_pkg::REG_RST;
      irq_r <= 1'b0;
    end else begin
      status_r <= status_nxt;
      mask_r <= mask_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign status = status_r;
  assign mask = mask_r;
  assign irq = irq_r;
endmodule // qsffc_irq

// file: rtl/qsffc_top.sv
/*
 * Quad serial Flash frame controller: AXI4-Lite registers, frame engine
 * and interrupts. Assumes link_clk is asynchronous and much slower than
 * aclk; all bus signals are synchronous to aclk.
 */
`timescale 1ns/1ns
module qsffc_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic link_clk,
  output logic flash_cs_n,
  input wire logic [3:0] flash_io_i,
  output logic [3:0] flash_io_o,
  output logic [3:0] flash_io_oe,
  output logic irq
);
  qsffc_pkg::qsffc_state_t state_r, state_nxt;
  logic aw_ok_r, aw_ok_nxt, w_ok_r, w_ok_nxt;
  logic [7:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt, wd;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic awready_r, awready_nxt, wready_r, wready_nxt;
  logic bvalid_r, bvalid_nxt, arready_r, arready_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [31:0] ifr_r, ifr_nxt, instr_r, instr_nxt, addr_r, addr_nxt;
  logic [7:0] txd_r, txd_nxt, skey_r, skey_nxt;
  logic scr_en_r, scr_en_nxt, start_r, start_nxt, wr_go;
  logic [31:0] stat_clr, en_set, en_clr, ev, status, mask;
  logic [31:0] cfg_r, cfg_nxt, cfg_use, sh_r, sh_nxt;
  logic [5:0] cnt_r, cnt_nxt;
  logic cs_n_r, cs_n_nxt, lk_q, lk_d_r, rise, fall, adv, is_wr;
  logic [3:0] io_o_r, io_o_nxt, io_oe_r, io_oe_nxt, io_q;
  logic [7:0] rx_sh_r, rx_sh_nxt, rxd_r, rxd_nxt, tx_byte;
  logic [2:0] ln;
  logic [1:0] ph;

  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0] s);
    wmerge = (old & ~qsffc_pkg::strb_mask(s)) |
             (d & qsffc_pkg::strb_mask(s));
  endfunction

  // Next enabled phase after cur, in fixed frame order
  function automatic qsffc_pkg::qsffc_state_t next_ph(
      input qsffc_pkg::qsffc_state_t cur, input logic [31:0] c);
    logic before_addr, before_opt, before_data;
    before_addr = (cur == qsffc_pkg::ST_IDLE) || (cur == qsffc_pkg::ST_INST);
    before_opt = before_addr || (cur == qsffc_pkg::ST_ADDR);
    before_data = before_opt || (cur == qsffc_pkg::ST_OPT);
    if (cur == qsffc_pkg::ST_IDLE && c[qsffc_pkg::IFR_INSTRUCTION_PHASE_EN])
      next_ph = qsffc_pkg::ST_INST;
    else if (before_addr && c[qsffc_pkg::IFR_ADDRESS_PHASE_EN])
      next_ph = qsffc_pkg::ST_ADDR;
    else if (before_opt && c[qsffc_pkg::IFR_OPTION_PHASE_EN])
      next_ph = qsffc_pkg::ST_OPT;
    else if (before_data && c[qsffc_pkg::IFR_DATA_PHASE_EN])
      next_ph = qsffc_pkg::ST_DATA;
    else
      next_ph = qsffc_pkg::ST_DONE;
  endfunction

  qsffc_sync #(.W(1)) u_lk_sync (
    .aclk(aclk), .aresetn(aresetn), .d(link_clk), .q(lk_q)
  );
  qsffc_sync #(.W(4)) u_io_sync (
    .aclk(aclk), .aresetn(aresetn), .d(flash_io_i), .q(io_q)
  );
  qsffc_irq u_irq (
    .aclk(aclk), .aresetn(aresetn), .ev_set(ev), .stat_clr(stat_clr),
    .en_set(en_set), .en_clr(en_clr), .status(status), .mask(mask),
    .irq(irq)
  );

  //////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave and register file
  assign wr_go = aw_ok_r && w_ok_r && !bvalid_r;
  assign wd = wdata_r & qsffc_pkg::strb_mask(wstrb_r);

  always_comb begin
    aw_ok_nxt = aw_ok_r;
    w_ok_nxt = w_ok_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    ifr_nxt = ifr_r;
    instr_nxt = instr_r;
    addr_nxt = addr_r;
    txd_nxt = txd_r;
    skey_nxt = skey_r;
    scr_en_nxt = scr_en_r;
    start_nxt = 1'b0;
    stat_clr = '0;
    en_set = '0;
    en_clr = '0;
    if (awvalid && awready_r) begin
      aw_ok_nxt = 1'b1;
      awaddr_nxt = awaddr;
    end
    if (wvalid && wready_r) begin
      w_ok_nxt = 1'b1;
      wdata_nxt = wdata;
      wstrb_nxt = wstrb;
    end
    if (bvalid_r && bready)
      bvalid_nxt = 1'b0;
    if (wr_go) begin
      aw_ok_nxt = 1'b0;
      w_ok_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = qsffc_pkg::RESP_OKAY;
      case (awaddr_r)
        qsffc_pkg::OFF_CTRL: begin
          if (wstrb_r[0])
            scr_en_nxt = wdata_r[qsffc_pkg::CTRL_SCREN];
          // A start while a frame runs is dropped
          start_nxt = wd[qsffc_pkg::CTRL_START] &&
                      state_r == qsffc_pkg::ST_IDLE && !start_r;
        end
        qsffc_pkg::OFF_STAT: stat_clr = wd;
        qsffc_pkg::OFF_IER: en_set = wd;
        qsffc_pkg::OFF_IDR: en_clr = wd;
        qsffc_pkg::OFF_INSTR: instr_nxt = wmerge(instr_r, wdata_r, wstrb_r);
        qsffc_pkg::OFF_ADDR: addr_nxt = wmerge(addr_r, wdata_r, wstrb_r);
        qsffc_pkg::OFF_IFR: ifr_nxt = wmerge(ifr_r, wdata_r, wstrb_r);
        qsffc_pkg::OFF_TXD: if (wstrb_r[0]) txd_nxt = wdata_r[7:0];
        qsffc_pkg::OFF_SKEY: if (wstrb_r[0]) skey_nxt = wdata_r[7:0];
        default: bresp_nxt = qsffc_pkg::RESP_SLVERR;
      endcase
    end
    if (arvalid && arready_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = qsffc_pkg::RESP_OKAY;
      rdata_nxt = '0;
      case (araddr)
        qsffc_pkg::OFF_CTRL: begin
          rdata_nxt[qsffc_pkg::CTRL_SCREN] = scr_en_r;
          rdata_nxt[qsffc_pkg::CTRL_BUSY] =
            (state_r != qsffc_pkg::ST_IDLE) || start_r;
        end
        qsffc_pkg::OFF_STAT: rdata_nxt = status;
        qsffc_pkg::OFF_IMR: rdata_nxt = mask;
        qsffc_pkg::OFF_INSTR: rdata_nxt = instr_r;
        qsffc_pkg::OFF_ADDR: rdata_nxt = addr_r;
        qsffc_pkg::OFF_IFR: rdata_nxt = ifr_r;
        qsffc_pkg::OFF_TXD: rdata_nxt[7:0] = txd_r;
        qsffc_pkg::OFF_RXD: rdata_nxt[7:0] = rxd_r;
        qsffc_pkg::OFF_SKEY: rdata_nxt[7:0] = skey_r;
        qsffc_pkg::OFF_IER, qsffc_pkg::OFF_IDR: rdata_nxt = '0;
        default: rresp_nxt = qsffc_pkg::RESP_SLVERR;
      endcase
    end else if (rvalid_r && rready) begin
      rvalid_nxt = 1'b0;
    end
    awready_nxt = !aw_ok_nxt && !bvalid_nxt;
    wready_nxt = !w_ok_nxt && !bvalid_nxt;
    arready_nxt = !rvalid_nxt;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ok_r <= 1'b0;
      w_ok_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= qsffc_pkg::RESP_OKAY;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rresp_r <= qsffc_pkg::RESP_OKAY;
      rdata_r <= '0;
      ifr_r <= qsffc_pkg::REG_RST;
      instr_r <= qsffc_pkg::REG_RST;
      addr_r <= qsffc_pkg::REG_RST;
      txd_r <= '0;
      skey_r <= '0;
      scr_en_r <= 1'b0;
      start_r <= 1'b0;
    end else begin
      aw_ok_r <= aw_ok_nxt;
      w_ok_r <= w_ok_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
      ifr_r <= ifr_nxt;
      instr_r <= instr_nxt;
      addr_r <= addr_nxt;
      txd_r <= txd_nxt;
      skey_r <= skey_nxt;
      scr_en_r <= scr_en_nxt;
      start_r <= start_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Frame engine
  assign rise = lk_q && !lk_d_r;
  assign fall = !lk_q && lk_d_r;
  assign cfg_use = (state_r == qsffc_pkg::ST_IDLE) ? ifr_r : cfg_r;
  assign is_wr = cfg_use[qsffc_pkg::IFR_TFR+1];
  assign ph = (state_r == qsffc_pkg::ST_INST) ? 2'h0 :
              (state_r == qsffc_pkg::ST_DATA) ? 2'h2 : 2'h1;
  assign ln = qsffc_pkg::lane_cnt(cfg_r[qsffc_pkg::IFR_WIDTH +: 3], ph);
  // Type 3 scrambles when enabled, type 2 never does
  assign tx_byte = txd_r ^ ((cfg_use[qsffc_pkg::IFR_TFR +: 2] ==
                   qsffc_pkg::TFR_MEM_WRITE && scr_en_r) ? skey_r : 8'h00);

  always_comb begin
    state_nxt = state_r;
    cfg_nxt = cfg_r;
    sh_nxt = sh_r;
    cnt_nxt = cnt_r;
    cs_n_nxt = cs_n_r;
    io_o_nxt = io_o_r;
    io_oe_nxt = io_oe_r;
    rx_sh_nxt = rx_sh_r;
    rxd_nxt = rxd_r;
    ev = '0;
    adv = 1'b0;
    case (state_r)
      qsffc_pkg::ST_IDLE: begin
        if (start_r) begin
          cfg_nxt = ifr_r;
          cs_n_nxt = 1'b0;
          ev[qsffc_pkg::IRQ_CSS] = 1'b1;
          adv = 1'b1;
        end
      end
      qsffc_pkg::ST_INST, qsffc_pkg::ST_ADDR, qsffc_pkg::ST_OPT,
      qsffc_pkg::ST_DATA: begin
        if (cnt_r == 6'h00) begin
          adv = 1'b1;
          if (state_r == qsffc_pkg::ST_DATA && !is_wr) begin
            rxd_nxt = rx_sh_r;
            ev[qsffc_pkg::IRQ_RECEIVE_HOLDING_FULL_IRQ_EN] = 1'b1;
            ev[qsffc_pkg::IRQ_RECEIVE_OVERRUN_IRQ_EN] = status[qsffc_pkg::IRQ_RECEIVE_HOLDING_FULL_IRQ_EN];
          end
        end else if (state_r == qsffc_pkg::ST_DATA && !is_wr) begin
          if (rise) begin
            rx_sh_nxt = (ln == 3'h4) ? {rx_sh_r[3:0], io_q} :
                        (ln == 3'h2) ? {rx_sh_r[5:0], io_q[1:0]} :
                        {rx_sh_r[6:0], io_q[1]};
            cnt_nxt = (cnt_r < {3'h0, ln}) ? 6'h00 : cnt_r - {3'h0, ln};
          end
        end else if (fall) begin
          io_o_nxt = (ln == 3'h4) ? sh_r[31:28] :
                     (ln == 3'h2) ? {2'h0, sh_r[31:30]} : {3'h0, sh_r[31]};
          io_oe_nxt = qsffc_pkg::lane_oe(ln);
          sh_nxt = sh_r << ln;
          cnt_nxt = (cnt_r < {3'h0, ln}) ? 6'h00 : cnt_r - {3'h0, ln};
        end
      end
      qsffc_pkg::ST_DONE: begin
        // Last bit held until the partner's sampling edge
        if (rise) begin
          cs_n_nxt = 1'b1;
          io_oe_nxt = 4'h0;
          ev[qsffc_pkg::IRQ_INSTRUCTION_END_IRQ_EN] = 1'b1;
          ev[qsffc_pkg::IRQ_CSR] = 1'b1;
          ev[qsffc_pkg::IRQ_CSS] = 1'b1;
          ev[qsffc_pkg::IRQ_TRANSMIT_REGS_DRAINED_IRQ_EN] = 1'b1;
          state_nxt = qsffc_pkg::ST_IDLE;
        end
      end
      default: state_nxt = qsffc_pkg::ST_IDLE;
    endcase
    if (adv) begin
      state_nxt = next_ph(state_r, cfg_use);
      case (state_nxt)
        qsffc_pkg::ST_INST: begin
          sh_nxt = {instr_r[7:0], 24'h000000};
          cnt_nxt = qsffc_pkg::INST_BITS;
        end
        qsffc_pkg::ST_ADDR: begin
          sh_nxt = cfg_use[qsffc_pkg::IFR_ADDRESS_LENGTH_SEL] ? addr_r :
                   {addr_r[23:0], 8'h00};
          cnt_nxt = cfg_use[qsffc_pkg::IFR_ADDRESS_LENGTH_SEL] ? qsffc_pkg::ADDR_LONG :
                    qsffc_pkg::ADDR_SHORT;
        end
        qsffc_pkg::ST_OPT: begin
          sh_nxt = {instr_r[23:16], 24'h000000};
          cnt_nxt = qsffc_pkg::opt_bits(cfg_use[qsffc_pkg::IFR_OPTION_CODE_LENGTH +: 2]);
        end
        qsffc_pkg::ST_DATA: begin
          sh_nxt = {tx_byte, 24'h000000};
          cnt_nxt = qsffc_pkg::DATA_BITS;
          ev[qsffc_pkg::IRQ_TRANSMIT_HOLDING_FREE_IRQ_EN] = is_wr;
          if (!is_wr)
            io_oe_nxt = 4'h0;
        end
        default: cnt_nxt = 6'h00;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= qsffc_pkg::ST_IDLE;
      cfg_r <= qsffc_pkg::REG_RST;
      sh_r <= '0;
      cnt_r <= '0;
      cs_n_r <= 1'b1;
      io_o_r <= 4'h0;
      io_oe_r <= 4'h0;
      rx_sh_r <= '0;
      rxd_r <= '0;
      lk_d_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cfg_r <= cfg_nxt;
      sh_r <= sh_nxt;
      cnt_r <= cnt_nxt;
      cs_n_r <= cs_n_nxt;
      io_o_r <= io_o_nxt;
      io_oe_r <= io_oe_nxt;
      rx_sh_r <= rx_sh_nxt;
      rxd_r <= rxd_nxt;
      lk_d_r <= lk_q;
    end
  end

  assign awready = awready_r;
  assign wready = wready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rresp = rresp_r;
  assign rdata = rdata_r;
  assign flash_cs_n = cs_n_r;
  assign flash_io_o = io_o_r;
  assign flash_io_oe = io_oe_r;

  //////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_enter_data;
    state_r != qsffc_pkg::ST_DATA && state_nxt == qsffc_pkg::ST_DATA;
  endsequence
  sequence s_start;
    state_r == qsffc_pkg::ST_IDLE && start_r;
  endsequence

  a_ier_sets_bits: assert property (wr_go && awaddr_r == qsffc_pkg::OFF_IER
    |=> (mask & $past(wd) & qsffc_pkg::IRQ_IMPL) ==
        ($past(wd) & qsffc_pkg::IRQ_IMPL))
    else $error("enable-set write did not enable its sources");
  a_ier_zero_keep: assert property (wr_go && awaddr_r == qsffc_pkg::OFF_IER
    |=> ($past(mask) & ~mask) == 32'h0)
    else $error("enable-set write cleared an enable");
  a_instruction_end_irq_en_irq_out: assert property (status[qsffc_pkg::IRQ_INSTRUCTION_END_IRQ_EN] &&
    mask[qsffc_pkg::IRQ_INSTRUCTION_END_IRQ_EN] |=> irq)
    else $error("instruction end interrupt not raised");
  a_receive_overrun_irq_en_irq_out: assert property (status[qsffc_pkg::IRQ_RECEIVE_OVERRUN_IRQ_EN] &&
    mask[qsffc_pkg::IRQ_RECEIVE_OVERRUN_IRQ_EN] |=> irq)
    else $error("overrun interrupt not raised");
  a_irq_quiet_low: assert property ((status & mask) == 32'h0 |=> !irq)
    else $error("interrupt raised with no enabled flag");
  a_plain_no_scramble: assert property (s_enter_data ##0
    (cfg_use[qsffc_pkg::IFR_TFR +: 2] == qsffc_pkg::TFR_PLAIN_WRITE)
    |=> sh_r[31:24] == $past(txd_r))
    else $error("plain write data was altered");
  a_mem_scramble_key: assert property (s_enter_data ##0
    (cfg_use[qsffc_pkg::IFR_TFR +: 2] == qsffc_pkg::TFR_MEM_WRITE)
    |=> sh_r[31:24] == ($past(txd_r) ^ ($past(scr_en_r) ? $past(skey_r)
        : 8'h00)))
    else $error("memory write scrambling wrong");
  a_addr_len_load: assert property (state_r != qsffc_pkg::ST_ADDR &&
    state_nxt == qsffc_pkg::ST_ADDR |=> cnt_r == ($past(cfg_use[10]) ?
    qsffc_pkg::ADDR_LONG : qsffc_pkg::ADDR_SHORT))
    else $error("address length wrong");
  a_opt_len_load: assert property (state_r != qsffc_pkg::ST_OPT &&
    state_nxt == qsffc_pkg::ST_OPT |=> cnt_r ==
    qsffc_pkg::opt_bits($past(cfg_use[9:8])))
    else $error("option length wrong");
  a_data_needs_en: assert property (state_r == qsffc_pkg::ST_DATA
    |-> cfg_r[qsffc_pkg::IFR_DATA_PHASE_EN])
    else $error("data phase while disabled");
  a_opt_needs_en: assert property (state_r == qsffc_pkg::ST_OPT
    |-> cfg_r[qsffc_pkg::IFR_OPTION_PHASE_EN])
    else $error("option phase while disabled");
  a_addr_needs_en: assert property (state_r == qsffc_pkg::ST_ADDR
    |-> cfg_r[qsffc_pkg::IFR_ADDRESS_PHASE_EN])
    else $error("address phase while disabled");
  a_inst_needs_en: assert property (state_r == qsffc_pkg::ST_INST
    |-> cfg_r[qsffc_pkg::IFR_INSTRUCTION_PHASE_EN])
    else $error("instruction phase while disabled");
  a_lane_drive: assert property (fall && cnt_r != 6'h00 &&
    state_r == qsffc_pkg::ST_ADDR |=> io_oe_r ==
    qsffc_pkg::lane_oe($past(ln)))
    else $error("lane enables do not match width");
  a_order_after_opt: assert property (state_r == qsffc_pkg::ST_OPT |=>
    state_r inside {qsffc_pkg::ST_OPT, qsffc_pkg::ST_DATA,
    qsffc_pkg::ST_DONE})
    else $error("phase order broken");
  a_start_frame: assert property (s_start |=> !flash_cs_n &&
    state_r != qsffc_pkg::ST_IDLE)
    else $error("frame did not open");
endmodule // qsffc_top

// file: dv/qsffc_flash_model.sv
/* Serial memory beside the frame controller: makes the link clock within
   frames and records the bits written on lane 0. Assumes cs_n from it. */
`timescale 1ns/1ns
module qsffc_flash_model (
  input wire logic cs_n,
  input wire logic [3:0] io_o,
  input wire logic [3:0] io_oe,
  output logic link_clk,
  output logic [3:0] io_i
);
  logic [63:0] bits = 64'h0;
  int nb = 0;
  initial link_clk = 1'h0;
  initial io_i = 4'h5;
  // Clock runs only while selected and rests low between frames
  always begin
    #80;
    if (!cs_n || link_clk) link_clk = ~link_clk;
  end
  // Idle lanes invert so no stale value lingers
  always @(negedge link_clk or posedge cs_n)
    io_i <= cs_n ? ~io_i : {io_i[2:0], ~^io_i};
  always @(negedge cs_n) begin
    bits <= 64'h0;
    nb <= 0;
  end
  // Sample well after the lane update that follows each fall
  always @(posedge link_clk) begin
    #70;
    if (io_oe[0]) begin
      bits <= {bits[62:0], io_o[0]};
      nb <= nb + 1;
    end
  end
endmodule // qsffc_flash_model

// file: dv/quad_serial_flash_frame_ctrl_tb.sv
/* Bench: AXI4-Lite tasks, enable mask, interrupt and frame checks.
   Assumes qsffc_top and the serial memory model beside it. */
`timescale 1ns/1ns
module quad_serial_flash_frame_ctrl_tb;
  logic aclk = 1'h0, aresetn = 1'h0;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0, ins, dat;
  logic [31:0] wdata = 32'h0, en = 32'h0, c, rd_v, adr, rdata;
  logic [3:0] wstrb = 4'hf, flash_io_i, flash_io_o, flash_io_oe;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, link_clk, flash_cs_n, irq;
  logic [1:0] bresp, rresp, rsp;
  logic [63:0] ev;
  int seed = 70, n_mismatch = 0, num_checks = 0, nexp, k;
  localparam logic [7:0] KEY = 8'h5a;
  localparam logic [31:0] CFG [8] = '{32'h30, 32'h770, 32'h40, 32'h140,
    32'h240, 32'h2080, 32'h3080, 32'h37f0};
  always #10 aclk = ~aclk;
  qsffc_top i_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .link_clk, .flash_cs_n,
    .flash_io_i, .flash_io_o, .flash_io_oe, .irq);
  qsffc_flash_model i_mem (.cs_n(flash_cs_n), .io_o(flash_io_o),
    .io_oe(flash_io_oe), .link_clk, .io_i(flash_io_i));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (1'b1) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (bvalid) begin
        rsp = bresp;
        bready <= 1'h0;
        break;
      end
    end
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    while (1'b1) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
      if (rvalid) begin
        rd_v = rdata;
        rsp = rresp;
        rready <= 1'h0;
        break;
      end
    end
  endtask
  // Bits expected on lane 0, phases in frame order
  function automatic logic [63:0] expv(input logic [31:0] f,
    input logic [31:0] a, input logic [7:0] d, output int n);
    logic [63:0] v;
    int l;
    v = {56'h0, ins};
    n = f[4] ? 8 : 0;
    l = f[10] ? 32 : 24;
    if (f[5]) v = (v << l) | (64'(a) & ((64'h1 << l) - 64'h1));
    n += f[5] ? l : 0;
    l = 1 << f[9:8];
    if (f[6]) v = (v << l) | ((64'h1 << l) - 64'h1);
    n += f[6] ? l : 0;
    if (f[7]) v = (v << 8) | 64'(f[13:12] == 2'h3 ? d ^ KEY : d);
    n += f[7] ? 8 : 0;
    expv = f[4] ? v : v & ((64'h1 << n) - 64'h1);
  endfunction
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #500000;
    n_mismatch++;
    test_done();
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    for (k = 0; k < 4; k++) begin
      c = (k == 3) ? 32'h0 : $random(seed);
      wr(qsffc_pkg::OFF_IER, c);
      en |= c & qsffc_pkg::IRQ_IMPL;
      rd(qsffc_pkg::OFF_IMR);
      chk(rd_v, en);
    end
    rd(8'h3c);
    chk(rsp, qsffc_pkg::RESP_SLVERR);
    wr(qsffc_pkg::OFF_SKEY, {24'h0, KEY});
    // Single lane throughout, so every option length suits it
    for (int j = 0; j < 8; j++) begin
      c = $random(seed);
      adr = $random(seed);
      ins = c[7:0];
      dat = c[15:8];
      ev = expv(CFG[j], adr, dat, nexp);
      wr(qsffc_pkg::OFF_IFR, CFG[j]);
      wr(qsffc_pkg::OFF_INSTR, {8'h0, 8'hff, 8'h0, ins});
      wr(qsffc_pkg::OFF_ADDR, adr);
      wr(qsffc_pkg::OFF_TXD, {24'h0, dat});
      wr(qsffc_pkg::OFF_IER, 32'h400);
      wr(qsffc_pkg::OFF_CTRL, 32'h3);
      for (k = 0; k < 3000 && flash_cs_n !== 1'h0; k++) @(posedge aclk);
      for (k = 0; k < 3000 && flash_cs_n !== 1'h1; k++) @(posedge aclk);
      repeat (4) @(posedge aclk);
      chk(i_mem.nb, nexp);
      chk(i_mem.bits, ev);
      chk(irq, 1'h1);
      wr(qsffc_pkg::OFF_IDR, 32'h70f);
      repeat (2) @(posedge aclk);
      chk(irq, 1'h0);
      wr(qsffc_pkg::OFF_STAT, 32'h70f);
      wr(qsffc_pkg::OFF_IER, 32'h400);
      repeat (2) @(posedge aclk);
      chk(irq, 1'h0);
    end
    test_done();
  end
endmodule // quad_serial_flash_frame_ctrl_tb
